// file: dv/sbsc_ctrl_props.sv
// Concurrent checks for the bank state and clock-enable control block.
`timescale 1ns/1ps
`default_nettype none
module sbsc_ctrl_props
	import sbsc_pkg::*;
#(
	parameter int BANKS = NUM_BANKS,
	parameter int BURST = BURST_LEN
)
(
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic ce, // Block enable
	input wire logic clk_gate_input, // Device clock enable
	input wire sbsc_strobes_t strobes, // Command strobes
	input wire logic [1:0] bank_select, // Bank address
	input wire logic precharge_all_addr_bit, // All-bank bit
	input wire sbsc_glb_state_t glb_state, // Global state
	input wire logic [3*BANKS-1:0] bank_states, // Bank states
	input wire logic all_idle, // All banks idle
	input wire logic cmd_accept, // Command taking
	input wire logic [1:0] last_burst_bank // Last burst bank
);
	logic cke_q;
	wire logic [2:0] b0 = bank_states[2:0];
	wire logic hold = strobes[3] || strobes == 4'h7;
	wire logic ok = cmd_accept && ce;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cke_q <= 1'h0;
		else if (ce)
			cke_q <= clk_gate_input;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_act;
		ok && strobes == 4'h3 && bank_select == 2'h0 && b0 == SBSC_BANK_IDLE
			|=> b0 == SBSC_BANK_ACTIVATING ##1 b0 == SBSC_BANK_ROW_ACTIVE;
	endproperty
	a_act: assert property (p_act) else $error("activate timing wrong");
	property p_idle_pre;
		ok && strobes == 4'h2 && b0 == SBSC_BANK_IDLE |=> b0 == SBSC_BANK_IDLE;
	endproperty
	a_idle_pre: assert property (p_idle_pre) else $error("idle precharge moved bank");
	property p_pre;
		ok && strobes == 4'h2 && (precharge_all_addr_bit || bank_select == 2'h0)
			&& b0 == SBSC_BANK_ROW_ACTIVE |=> b0 == SBSC_BANK_PRECHARGING ##1 b0 == SBSC_BANK_IDLE;
	endproperty
	a_pre: assert property (p_pre) else $error("precharge timing wrong");
	property p_read;
		ok && strobes == 4'h5 && bank_select == 2'h0 && b0 == SBSC_BANK_ROW_ACTIVE
			|=> b0 == SBSC_BANK_READING;
	endproperty
	a_read: assert property (p_read) else $error("read not started");
	property p_term;
		ok && strobes == 4'h6 && last_burst_bank == 2'h0 && b0 == SBSC_BANK_READING
			|=> b0 == SBSC_BANK_ROW_ACTIVE || b0 == SBSC_BANK_PRECHARGING;
	endproperty
	a_term: assert property (p_term) else $error("terminate missed burst");
	property p_ref;
		ok && strobes == 4'h1 && all_idle
			|=> glb_state == SBSC_GLB_REFRESHING ##1 glb_state == SBSC_GLB_NORMAL && all_idle;
	endproperty
	a_ref: assert property (p_ref) else $error("refresh timing wrong");
	property p_mode;
		ok && strobes == 4'h0 && all_idle
			|=> glb_state == SBSC_GLB_MODE_ACCESS ##1 glb_state == SBSC_GLB_NORMAL && all_idle;
	endproperty
	a_mode: assert property (p_mode) else $error("mode access timing wrong");
	property p_pd_in;
		cke_q && !clk_gate_input && hold && all_idle |=> glb_state == SBSC_GLB_POWER_DOWN;
	endproperty
	a_pd_in: assert property (p_pd_in) else $error("power-down not entered");
	property p_keep;
		glb_state inside {SBSC_GLB_POWER_DOWN, SBSC_GLB_SELF_REFRESH, SBSC_GLB_CLOCK_SUSPEND}
			&& !clk_gate_input |=> $stable(glb_state);
	endproperty
	a_keep: assert property (p_keep) else $error("low power state left");
	property p_pd_out;
		glb_state == SBSC_GLB_POWER_DOWN && !cke_q && clk_gate_input && hold
			|=> glb_state == SBSC_GLB_NORMAL && all_idle;
	endproperty
	a_pd_out: assert property (p_pd_out) else $error("power-down exit late");
	property p_sr_out;
		glb_state == SBSC_GLB_SELF_REFRESH && !cke_q && clk_gate_input && hold
			|=> glb_state == SBSC_GLB_SELF_EXIT [*2] ##1 glb_state == SBSC_GLB_NORMAL;
	endproperty
	a_sr_out: assert property (p_sr_out) else $error("self refresh exit wrong");
	property p_susp;
		glb_state == SBSC_GLB_CLOCK_SUSPEND && clk_gate_input |=> glb_state == SBSC_GLB_NORMAL;
	endproperty
	a_susp: assert property (p_susp) else $error("suspend exit late");
endmodule // sbsc_ctrl_props
bind sbsc_ctrl sbsc_ctrl_props #(.BANKS(BANKS), .BURST(BURST)) i_props (.clk(clk), .rst_n(rst_n),
	.ce(ce), .clk_gate_input(clk_gate_input), .strobes(strobes), .bank_select(bank_select),
	.precharge_all_addr_bit(precharge_all_addr_bit), .glb_state(glb_state),
	.bank_states(bank_states), .all_idle(all_idle), .cmd_accept(cmd_accept),
	.last_burst_bank(last_burst_bank));
`default_nettype wire

// file: dv/sbsc_host_model.sv
// Behavioural memory controller that drives commands and clock enable.
`timescale 1ns/1ps
`default_nettype none
module sbsc_host_model
	import sbsc_pkg::*;
(
	input wire logic clk, // Clock
	output sbsc_strobes_t strobes, // Command strobes
	output logic [1:0] bank_select, // Bank address
	output logic precharge_all_addr_bit, // All-bank or auto precharge bit
	output logic clk_gate_input // Device clock enable
);
	initial
	begin
		strobes = 4'hF;
		bank_select = 2'h0;
		precharge_all_addr_bit = 1'h0;
		clk_gate_input = 1'h1;
	end
	// Callers keep bank, global and all-bank precharge timing legal; the bank address toggles on NOP and inhibit, the all-bank bit whenever unused.
	task automatic send(input logic [3:0] c, input logic [1:0] b, input logic a, input logic k);
		@(posedge clk);
		strobes <= c;
		clk_gate_input <= k;
		bank_select <= (c == 4'h7 || c[3]) ? ~bank_select : b;
		precharge_all_addr_bit <= (c == 4'h2 || c[3:1] == 3'h2) ? a : ~precharge_all_addr_bit;
	endtask
endmodule // sbsc_host_model
`default_nettype wire

// file: dv/test_sbsc_ctrl.sv
// Self-checking testbench for the bank state and clock-enable control block.
`timescale 1ns/1ps
`default_nettype none
module test_sbsc_ctrl
	import sbsc_pkg::*;
;
	localparam logic [3:0] LMR = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3;
	localparam logic [3:0] WR = 4'h4, RD = 4'h5, BT = 4'h6, NOP = 4'h7;
	localparam sbsc_bank_state_t IDL = SBSC_BANK_IDLE, ACG = SBSC_BANK_ACTIVATING;
	localparam sbsc_bank_state_t RAC = SBSC_BANK_ROW_ACTIVE, RDG = SBSC_BANK_READING;
	localparam sbsc_bank_state_t WRG = SBSC_BANK_WRITING, PRG = SBSC_BANK_PRECHARGING;
	logic clk, rst_n, ce, a10, cke, all_idle, cmd_accept;
	sbsc_strobes_t strobes;
	logic [1:0] bank_select, last_burst_bank;
	sbsc_glb_state_t glb_state;
	logic [11:0] bs;
	int n_errors = 0, tests_run = 0, cyc = 0;
	sbsc_ctrl i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .clk_gate_input(cke), .strobes(strobes),
		.bank_select(bank_select), .precharge_all_addr_bit(a10), .glb_state(glb_state),
		.bank_states(bs), .all_idle(all_idle), .cmd_accept(cmd_accept),
		.last_burst_bank(last_burst_bank));
	sbsc_host_model i_host (.clk(clk), .strobes(strobes), .bank_select(bank_select),
		.precharge_all_addr_bit(a10), .clk_gate_input(cke));
	task automatic s(input logic [3:0] c, input logic [1:0] b = 2'h0, input logic a = 1'h0,
		input logic k = 1'h1);
		i_host.send(c, b, a, k);
		#1;
	endtask
	task automatic ck(input string n, input logic [2:0] e, input logic [2:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task t_global;
		s(REF);
		s(NOP); ck("refresh", SBSC_GLB_REFRESHING, glb_state);
		s(LMR); ck("ref_end", SBSC_GLB_NORMAL, glb_state);
		s(NOP); ck("mode", SBSC_GLB_MODE_ACCESS, glb_state);
		s(NOP); ck("mode_end", 3'h1, {2'h0, all_idle});
	endtask
	task t_power;
		s(NOP, 0, 0, 0);
		s(ACT, 0, 0, 0); ck("pd_in", SBSC_GLB_POWER_DOWN, glb_state);
		s(NOP, 0, 0, 0); ck("pd_hold", SBSC_GLB_POWER_DOWN, glb_state);
		s(NOP); ck("pd_low", SBSC_GLB_POWER_DOWN, glb_state);
		s(NOP); ck("pd_out", SBSC_GLB_NORMAL, glb_state);
		ck("pd_bank", IDL, bs[2:0]);
	endtask
	task t_self;
		s(REF, 0, 0, 0);
		s(NOP, 0, 0, 0); ck("sr_in", SBSC_GLB_SELF_REFRESH, glb_state);
		s(NOP); ck("sr_hold", SBSC_GLB_SELF_REFRESH, glb_state);
		s(NOP); ck("sr_exit", SBSC_GLB_SELF_EXIT, glb_state);
		ck("sr_block", 3'h0, {2'h0, cmd_accept});
		s(NOP); ck("sr_exit2", SBSC_GLB_SELF_EXIT, glb_state);
		s(NOP); ck("sr_done", 3'h1, {2'h0, cmd_accept});
		ck("sr_normal", SBSC_GLB_NORMAL, glb_state);
	endtask
	task t_burst;
		s(ACT);
		s(NOP); ck("act", ACG, bs[2:0]);
		s(RD); ck("row", RAC, bs[2:0]);
		s(WR); ck("read", RDG, bs[2:0]);
		s(RD); ck("rd_wr", WRG, bs[2:0]);
		s(BT); ck("wr_rd", RDG, bs[2:0]);
		s(PRE); ck("term", RAC, bs[2:0]);
		s(NOP); ck("pre", PRG, bs[2:0]);
		s(NOP); ck("idle", IDL, bs[2:0]);
	endtask
	task t_other;
		s(ACT, 1);
		s(ACT, 2);
		s(RD, 1);
		s(BT, 2); ck("rd1", RDG, bs[5:3]);
		s(RD, 1, 1); ck("term1", RAC, bs[5:3]);
		ck("last", 3'h1, {1'h0, last_burst_bank});
		s(NOP); ck("ap_rd", RDG, bs[5:3]);
		repeat (BURST_LEN) s(NOP);
		ck("ap_pre", PRG, bs[5:3]);
		s(PRE, 0, 1); ck("ap_idle", IDL, bs[5:3]);
		s(NOP); ck("all_pre", PRG, bs[8:6]);
		ck("idle_pre", IDL, bs[2:0]);
		s(NOP); ck("all_idle", 3'h1, {2'h0, all_idle});
	endtask
	task t_freeze;
		s(RD, 2'h3);
		s(NOP); ck("fz_rd", RDG, bs[11:9]);
		@(posedge clk) ce <= 1'h0;
		repeat (5) @(posedge clk);
		ce <= 1'h1;
		#1;
		ck("fz_hold", RDG, bs[11:9]);
		repeat (2) s(NOP);
		ck("fz_run", RDG, bs[11:9]);
		s(NOP); ck("fz_end", RAC, bs[11:9]);
	endtask
	task t_reset;
		@(posedge clk) rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		#1;
		ck("rst_bank", IDL, bs[11:9]);
		ck("rst_last", 3'h0, {1'h0, last_burst_bank});
		ck("rst_acc", 3'h0, {2'h0, cmd_accept});
		s(NOP); ck("rst_acc2", 3'h1, {2'h0, cmd_accept});
	endtask
	task t_susp;
		s(ACT, 3);
		s(NOP);
		s(RD, 3);
		s(NOP, 0, 0, 0); ck("rd3", RDG, bs[11:9]);
		s(NOP, 0, 0, 0); ck("susp", SBSC_GLB_CLOCK_SUSPEND, glb_state);
		repeat (6) s(NOP, 0, 0, 0);
		ck("susp_hold", SBSC_GLB_CLOCK_SUSPEND, glb_state);
		ck("susp_frozen", RDG, bs[11:9]);
		s(NOP);
		s(BT); ck("susp_out", SBSC_GLB_NORMAL, glb_state);
		s(NOP); ck("susp_cmd", RAC, bs[11:9]);
	endtask
	initial
	begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			n_errors++;
			conclude();
		end
	end
	initial
	begin
		rst_n = 1'h0;
		ce = 1'h1;
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		s(NOP);
		s(NOP);
		t_global();
		t_power();
		t_self();
		t_burst();
		t_other();
		t_susp();
		t_freeze();
		t_reset();
		conclude();
	end
endmodule // test_sbsc_ctrl
`default_nettype wire

// file: hw/sbsc_bank.sv
// State tracker for one bank.
`timescale 1ns/1ps
`default_nettype none
module sbsc_bank
	import sbsc_pkg::*;
#(
	parameter int BURST = BURST_LEN
)
(
	input wire logic clk, // Clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic ce, // Clock enable of the block
	input wire logic run, // Bank timers and bursts advance
	input wire logic accept, // Commands may be taken this edge
	input wire sbsc_bank_req_t req, // Request addressed to this bank
	output sbsc_bank_state_t state, // Current bank state
	output logic auto_pre // Current burst has auto precharge
);
	sbsc_bank_state_t state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic auto_pre_reg;

	assign state = state_reg;
	assign auto_pre = auto_pre_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= SBSC_BANK_IDLE;
			cnt_reg <= 4'h0;
			auto_pre_reg <= 1'b0;
		end
		else if (ce && run)
		begin
			if (accept && (req.read || req.write) &&
				(state_reg == SBSC_BANK_ROW_ACTIVE || (!auto_pre_reg &&
				(state_reg == SBSC_BANK_READING || state_reg == SBSC_BANK_WRITING))))
			begin
				state_reg <= req.read ? SBSC_BANK_READING : SBSC_BANK_WRITING;
				cnt_reg <= CNT_W'(BURST);
				auto_pre_reg <= req.auto_pre;
			end
			else if (accept && req.precharge && state_reg != SBSC_BANK_IDLE &&
				state_reg != SBSC_BANK_PRECHARGING)
			begin
				state_reg <= SBSC_BANK_PRECHARGING;
				cnt_reg <= CNT_W'(PRECHARGE_CYC);
				auto_pre_reg <= 1'b0;
			end
			else if (accept && req.activate && state_reg == SBSC_BANK_IDLE)
			begin
				state_reg <= SBSC_BANK_ACTIVATING;
				cnt_reg <= CNT_W'(ACT_TO_RW_CYC);
			end
			else if (accept && req.terminate &&
				(state_reg == SBSC_BANK_READING || state_reg == SBSC_BANK_WRITING))
			begin
				state_reg <= auto_pre_reg ? SBSC_BANK_PRECHARGING : SBSC_BANK_ROW_ACTIVE;
				cnt_reg <= CNT_W'(PRECHARGE_CYC);
				auto_pre_reg <= 1'b0;
			end
			else if (state_reg != SBSC_BANK_IDLE && state_reg != SBSC_BANK_ROW_ACTIVE)
			begin
				if (cnt_reg > 4'h1)
					cnt_reg <= cnt_reg - 4'h1;
				else
				begin
					unique case (state_reg)
						SBSC_BANK_ACTIVATING: state_reg <= SBSC_BANK_ROW_ACTIVE;
						SBSC_BANK_PRECHARGING: state_reg <= SBSC_BANK_IDLE;
						SBSC_BANK_READING, SBSC_BANK_WRITING:
						begin
							state_reg <= auto_pre_reg ? SBSC_BANK_PRECHARGING : SBSC_BANK_ROW_ACTIVE;
							cnt_reg <= CNT_W'(PRECHARGE_CYC);
							auto_pre_reg <= 1'b0;
						end
						default: state_reg <= SBSC_BANK_IDLE;
					endcase
				end
			end
		end
	end
endmodule // sbsc_bank
`default_nettype wire

// file: hw/sbsc_cmd_decode.sv
// Command decoder from the four command strobes.
`timescale 1ns/1ps
`default_nettype none
module sbsc_cmd_decode
	import sbsc_pkg::*;
(
	input wire sbsc_strobes_t strobes, // Sampled command strobes
	output sbsc_cmd_t cmd // Decoded command
);
	always_comb
	begin
		if (strobes.chip_select_n)
			cmd = SBSC_CMD_INHIBIT;
		else
		begin
			unique case ({strobes.row_strobe_n, strobes.column_strobe_n, strobes.write_strobe_n})
				3'h7: cmd = SBSC_CMD_NOP;
				3'h3: cmd = SBSC_CMD_ACTIVATE;
				3'h5: cmd = SBSC_CMD_READ;
				3'h4: cmd = SBSC_CMD_WRITE;
				3'h2: cmd = SBSC_CMD_PRECHARGE;
				3'h6: cmd = SBSC_CMD_BURST_TERM;
				3'h1: cmd = SBSC_CMD_AUTO_REFRESH;
				3'h0: cmd = SBSC_CMD_LOAD_MODE;
			endcase
		end
	end
endmodule // sbsc_cmd_decode
`default_nettype wire

// file: hw/sbsc_ctrl.sv
// Top level: clock-enable power states, global states and four bank trackers.
`timescale 1ns/1ps
`default_nettype none
module sbsc_ctrl
	import sbsc_pkg::*;
#(
	parameter int BANKS = NUM_BANKS,
	parameter int BURST = BURST_LEN
)
(
	input wire logic clk, // Clock, 10 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic ce, // Block clock enable; freezes all state when low
	input wire logic clk_gate_input, // Device clock-enable pin
	input wire sbsc_strobes_t strobes, // Command strobes, active low
	input wire logic [1:0] bank_select, // Bank address
	input wire logic precharge_all_addr_bit, // Precharge all or auto precharge bit
	output sbsc_glb_state_t glb_state, // Global state
	output logic [3*BANKS-1:0] bank_states, // Per-bank states, bank 0 lowest
	output logic all_idle, // Every bank idle and no global operation
	output logic cmd_accept, // Bank command taking is enabled this edge
	output logic [1:0] last_burst_bank // Bank of the most recent burst
);
	// ********************************************************************
	// Command decode and clock-enable history
	// ********************************************************************
	sbsc_cmd_t cmd;
	sbsc_glb_state_t glb_reg;
	logic cke_prev_reg;
	logic [CNT_W-1:0] glb_cnt_reg;
	logic [1:0] last_bank_reg;
	logic burst_live;
	logic banks_idle;
	logic nop_like;
	logic cke_hold;
	logic run;
	sbsc_bank_state_t bst [BANKS];
	logic [BANKS-1:0] bank_idle_v;
	logic [BANKS-1:0] bank_burst_v;

	sbsc_cmd_decode u_dec
	(
		.strobes(strobes),
		.cmd(cmd)
	);

	assign nop_like = (cmd == SBSC_CMD_INHIBIT) || (cmd == SBSC_CMD_NOP);
	assign cke_hold = cke_prev_reg && clk_gate_input;
	assign banks_idle = &bank_idle_v;
	assign burst_live = |bank_burst_v;
	assign all_idle = banks_idle && (glb_reg == SBSC_GLB_NORMAL);
	assign glb_state = glb_reg;
	assign last_burst_bank = last_bank_reg;
	assign cmd_accept = cke_hold && (glb_reg == SBSC_GLB_NORMAL);
	// Bank timers run except in power-down, self refresh, clock suspend and the cycle in which the clock enable falls.
	assign run = (glb_reg != SBSC_GLB_CLOCK_SUSPEND) && (glb_reg != SBSC_GLB_POWER_DOWN) &&
		(glb_reg != SBSC_GLB_SELF_REFRESH) && !(cke_prev_reg && !clk_gate_input);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cke_prev_reg <= 1'b0;
		else if (ce)
			cke_prev_reg <= clk_gate_input;
	end

	// ********************************************************************
	// Global state machine
	// ********************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			glb_reg <= SBSC_GLB_NORMAL;
			glb_cnt_reg <= 4'h0;
		end
		else if (ce)
		begin
			unique case (glb_reg)
				SBSC_GLB_NORMAL:
				begin
					if (cke_prev_reg && !clk_gate_input)
					begin
						if (burst_live)
							glb_reg <= SBSC_GLB_CLOCK_SUSPEND;
						else if (banks_idle && cmd == SBSC_CMD_AUTO_REFRESH)
							glb_reg <= SBSC_GLB_SELF_REFRESH;
						else if (banks_idle && nop_like)
							glb_reg <= SBSC_GLB_POWER_DOWN;
					end
					else if (cke_hold && banks_idle && cmd == SBSC_CMD_AUTO_REFRESH)
					begin
						glb_reg <= SBSC_GLB_REFRESHING;
						glb_cnt_reg <= CNT_W'(REFRESH_CYC);
					end
					else if (cke_hold && banks_idle && cmd == SBSC_CMD_LOAD_MODE)
					begin
						glb_reg <= SBSC_GLB_MODE_ACCESS;
						glb_cnt_reg <= CNT_W'(MODE_LOAD_CYC);
					end
				end
				SBSC_GLB_REFRESHING, SBSC_GLB_MODE_ACCESS:
				begin
					if (glb_cnt_reg > 4'h1)
						glb_cnt_reg <= glb_cnt_reg - 4'h1;
					else
						glb_reg <= SBSC_GLB_NORMAL;
				end
				SBSC_GLB_POWER_DOWN:
				begin
					if (!cke_prev_reg && clk_gate_input && nop_like)
						glb_reg <= SBSC_GLB_NORMAL;
				end
				SBSC_GLB_SELF_REFRESH:
				begin
					if (!cke_prev_reg && clk_gate_input && nop_like)
					begin
						glb_reg <= SBSC_GLB_SELF_EXIT;
						glb_cnt_reg <= CNT_W'(SELF_EXIT_CYC);
					end
				end
				SBSC_GLB_SELF_EXIT:
				begin
					if (glb_cnt_reg > 4'h1)
						glb_cnt_reg <= glb_cnt_reg - 4'h1;
					else
						glb_reg <= SBSC_GLB_NORMAL;
				end
				SBSC_GLB_CLOCK_SUSPEND:
				begin
					if (!cke_prev_reg && clk_gate_input)
						glb_reg <= SBSC_GLB_NORMAL;
				end
				default: glb_reg <= SBSC_GLB_NORMAL;
			endcase
		end
	end

	// ********************************************************************
	// Most recent burst tracking
	// ********************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			last_bank_reg <= 2'h0;
		else if (ce && cmd_accept && (cmd == SBSC_CMD_READ || cmd == SBSC_CMD_WRITE))
			last_bank_reg <= bank_select;
	end

	// ********************************************************************
	// Bank trackers
	// ********************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < BANKS; gi++)
		begin : g_bank
			sbsc_bank_req_t req;
			logic hit;
			assign hit = (bank_select == 2'(gi));
			always_comb
			begin
				req.activate = (cmd == SBSC_CMD_ACTIVATE) && hit;
				req.read = (cmd == SBSC_CMD_READ) && hit;
				req.write = (cmd == SBSC_CMD_WRITE) && hit;
				req.precharge = (cmd == SBSC_CMD_PRECHARGE) &&
					(precharge_all_addr_bit || hit);
				req.auto_pre = precharge_all_addr_bit;
				// A new burst on another bank hands the terminate target over.
				req.terminate = (cmd == SBSC_CMD_BURST_TERM) && (last_bank_reg == 2'(gi));
			end
			sbsc_bank #(
				.BURST(BURST)
			) u_bank
			(
				.clk(clk),
				.rst_n(rst_n),
				.ce(ce),
				.run(run),
				.accept(cmd_accept),
				.req(req),
				.state(bst[gi]),
				.auto_pre()
			);
			assign bank_idle_v[gi] = (bst[gi] == SBSC_BANK_IDLE);
			assign bank_burst_v[gi] = (bst[gi] == SBSC_BANK_READING) ||
				(bst[gi] == SBSC_BANK_WRITING);
			assign bank_states[3*gi +: 3] = bst[gi];
		end
	endgenerate

endmodule // sbsc_ctrl
`default_nettype wire

// file: hw/sbsc_pkg.sv
// Package of constants and types for the SDRAM bank state and clock-enable control block.
package sbsc_pkg;

	// ********************************************************************
	// Timing counts in clock cycles (10 MHz, 100 ns period)
	// ********************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int PRECHARGE_TIME_NS = 20;
	localparam int ACT_TO_RW_DELAY_NS = 20;
	localparam int REFRESH_CYCLE_TIME_NS = 70;
	localparam int MODE_LOAD_TIME_NS = 20;
	localparam int SELF_REFRESH_EXIT_TIME_NS = 80;
	localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACT_TO_RW_CYC = (ACT_TO_RW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFRESH_CYC = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MODE_LOAD_CYC = (MODE_LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELF_EXIT_CYC_RAW = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELF_EXIT_MIN_NOP = 2;
	localparam int SELF_EXIT_CYC = (SELF_EXIT_CYC_RAW < SELF_EXIT_MIN_NOP) ?
		SELF_EXIT_MIN_NOP : SELF_EXIT_CYC_RAW;
	localparam int BURST_LEN = 4;
	localparam int NUM_BANKS = 4;
	localparam int CNT_W = 4;

	// ********************************************************************
	// Command and state encodings
	// ********************************************************************
	typedef enum logic [3:0] {
		SBSC_CMD_INHIBIT = 4'h0,
		SBSC_CMD_NOP = 4'h1,
		SBSC_CMD_ACTIVATE = 4'h2,
		SBSC_CMD_READ = 4'h3,
		SBSC_CMD_WRITE = 4'h4,
		SBSC_CMD_PRECHARGE = 4'h5,
		SBSC_CMD_BURST_TERM = 4'h6,
		SBSC_CMD_AUTO_REFRESH = 4'h7,
		SBSC_CMD_LOAD_MODE = 4'h8
	} sbsc_cmd_t;

	typedef enum logic [2:0] {
		SBSC_BANK_IDLE = 3'h0,
		SBSC_BANK_ACTIVATING = 3'h1,
		SBSC_BANK_ROW_ACTIVE = 3'h2,
		SBSC_BANK_READING = 3'h3,
		SBSC_BANK_WRITING = 3'h4,
		SBSC_BANK_PRECHARGING = 3'h5
	} sbsc_bank_state_t;

	typedef enum logic [2:0] {
		SBSC_GLB_NORMAL = 3'h0,
		SBSC_GLB_REFRESHING = 3'h1,
		SBSC_GLB_MODE_ACCESS = 3'h2,
		SBSC_GLB_POWER_DOWN = 3'h3,
		SBSC_GLB_SELF_REFRESH = 3'h4,
		SBSC_GLB_SELF_EXIT = 3'h5,
		SBSC_GLB_CLOCK_SUSPEND = 3'h6
	} sbsc_glb_state_t;

	typedef struct packed {
		logic chip_select_n;
		logic row_strobe_n;
		logic column_strobe_n;
		logic write_strobe_n;
	} sbsc_strobes_t;

	// Decoded bank-level request handed to each bank tracker.
	typedef struct packed {
		logic activate;
		logic read;
		logic write;
		logic precharge;
		logic auto_pre;
		logic terminate;
	} sbsc_bank_req_t;

endpackage : sbsc_pkg
